// file: src/scps_ctrl.sv
// Purpose: clock source selection and pll control with avalon-mm registers
// Assumes: single 20 MHz clock; pll lock pin is asynchronous to it
// Notes: clock changes are applied with the system clock gated off
//
// Notes on behaviour
// - two fast sources and two slow sources are offered.
// - slow_source_select picks external slow crystal or internal slow rc.
// - fast_source_select picks external fast crystal or internal fast rc.
// - clock_select_field picks fast or slow clock and the system frequency.
// - system clock selection can change while running.
// - exactly one fast and one slow source always selected.
// - selected oscillators also clock the watchdog and time base.
// - pll_enable switches the pll and reads 1 after reset.
// - enabled pll gives a fixed 48 MHz usb clock.
// - fast clock is the oscillator when pll off or select top bit 0.
// - select codes 100, 101, 110 give 6, 12, 16 MHz; 111 reserved.
// - pll_input_rate_select declares 12 MHz at 0, 6 MHz at 1.
// - with a 12 MHz reference the pll halves then multiplies by eight.
// - with a 6 MHz reference the pll multiplies by eight directly.
// - internal fast rc selected forces pll_input_rate_select to 0.
// - changing pll_enable from 0 to 1 clears the lock flag; it sets once stable.
// - pll reference comes from the selected fast oscillator.
`timescale 1ns/100ps

module scps_ctrl
  import scps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // analog pll
  input wire logic pll_locked_pin,
  output scps_pll_cfg_t pll_cfg,
  // clock tree
  output scps_clk_sel_t clk_sel,
  output logic sys_clk_gate,
  output logic [3:0] osc_run,
  output scps_aux_sel_t aux_sel,
  // interrupt
  output logic irq
);

  typedef enum logic [1:0] {SW_RUN, SW_GATE, SW_LOAD, SW_UNGATE} scps_sw_state_t;

  // system frequency from clock_select_field: 000 slow, 111 undivided fast
  function automatic logic [2:0] scps_div_of(input logic [2:0] cks);
    scps_div_of = 3'h7 - cks;
  endfunction

  // register offset decode, used by both read and write paths
  function automatic logic scps_hit(input logic [4:0] addr, input logic [4:0] ofs);
    scps_hit = (addr == ofs);
  endfunction

  logic wait_r;
  logic [31:0] rdata_r;
  logic [2:0] cks_r;
  logic fhs_r;
  logic fss_r;
  logic pll_en_r;
  logic pll_is_r;
  logic [2:0] pll_os_r;
  logic pll_rsv_r;
  logic lock_flag_r;
  logic lock_flag_nxt;
  logic lk_s1_r;
  logic lk_s2_r;
  logic lk_s3_r;
  logic lk_stable_r;
  logic [7:0] settle_cnt_r;
  logic [2:0] sts_r;
  logic [2:0] sts_nxt;
  logic [2:0] msk_r;
  logic irq_r;
  scps_sw_state_t sw_state_r;
  logic [2:0] gap_cnt_r;
  logic gate_r;
  logic sw_done_r;
  scps_clk_sel_t cur_r;
  scps_clk_sel_t tgt;
  scps_pll_cfg_t pll_cfg_r;
  logic [3:0] osc_run_r;
  scps_aux_sel_t aux_r;
  logic [7:0] rd_mux;
  logic wr_go;
  logic rd_go;
  logic en_rise;
  logic [7:0] wbyte;

  assign wbyte = avs_writedata[7:0];
  // a write lands only at the edge where waitrequest is seen low
  assign wr_go = avs_write & ~wait_r & avs_byteenable[0];
  assign rd_go = avs_read & ~wait_r;
  // lock restarts only on a 0 to 1 change, so rewriting 1 cannot glitch a running pll
  assign en_rise = wr_go & scps_hit(avs_address, OFS_PLL_CONTROL)
                   & wbyte[PLL_CONTROL_EN_BIT] & ~pll_en_r;

  // one wait cycle per transfer: readdata is captured in the waiting cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_r <= 1'b1;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if (avs_read || avs_write) begin
      wait_r <= 1'b0;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 8'h00;
    if (scps_hit(avs_address, OFS_SYS_CLOCK_CONTROL)) begin
      rd_mux = {cks_r, 1'b0, fhs_r, fss_r, 2'b00};
    end else if (scps_hit(avs_address, OFS_PLL_CONTROL)) begin
      rd_mux = {pll_rsv_r, 1'b0, pll_is_r, pll_os_r, lock_flag_r, pll_en_r};
    end else if (scps_hit(avs_address, OFS_INT_STATUS)) begin
      rd_mux = {5'h00, sts_r};
    end else if (scps_hit(avs_address, OFS_INT_MASK)) begin
      rd_mux = {5'h00, msk_r};
    end else if (scps_hit(avs_address, OFS_CLK_STATUS)) begin
      rd_mux = {3'h0, cur_r.slow_src, cur_r.fast_src, cur_r.use_slow, cur_r.use_pll,
                (sw_state_r != SW_RUN)};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (wait_r && avs_read) begin
      rdata_r <= {24'h00_0000, rd_mux};
    end
  end

  // sys_clock_control: sources and system frequency can be rewritten at any time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cks_r <= SCC_RESET[SCC_CKS_LSB +: 3];
      fhs_r <= SCC_RESET[SCC_FHS_BIT];
      fss_r <= SCC_RESET[SCC_FSS_BIT];
    end else if (wr_go && scps_hit(avs_address, OFS_SYS_CLOCK_CONTROL)) begin
      cks_r <= wbyte[SCC_CKS_LSB +: 3];
      fhs_r <= wbyte[SCC_FHS_BIT];
      fss_r <= wbyte[SCC_FSS_BIT];
    end
  end

  // pll_control; enable comes up set so the pll starts after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_en_r <= PLL_CONTROL_RESET[PLL_CONTROL_EN_BIT];
      pll_os_r <= PLL_CONTROL_RESET[PLL_CONTROL_OS_LSB +: 3];
      pll_rsv_r <= PLL_CONTROL_RESET[PLL_CONTROL_RSV_BIT];
    end else if (wr_go && scps_hit(avs_address, OFS_PLL_CONTROL)) begin
      pll_en_r <= wbyte[PLL_CONTROL_EN_BIT];
      pll_os_r <= wbyte[PLL_CONTROL_OS_LSB +: 3];
      pll_rsv_r <= wbyte[PLL_CONTROL_RSV_BIT];
    end
  end

  // input rate: held at 12 MHz whenever the internal rc is the fast source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_is_r <= PLL_CONTROL_RESET[PLL_CONTROL_IS_BIT];
    end else if (!fhs_r) begin
      pll_is_r <= 1'b0;
    end else if (wr_go && scps_hit(avs_address, OFS_PLL_CONTROL)) begin
      pll_is_r <= wbyte[PLL_CONTROL_IS_BIT];
    end
  end

  // lock pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lk_s1_r <= 1'b0;
      lk_s2_r <= 1'b0;
      lk_s3_r <= 1'b0;
      lk_stable_r <= 1'b0;
    end else begin
      lk_s1_r <= pll_locked_pin;
      lk_s2_r <= lk_s1_r;
      lk_s3_r <= lk_s2_r;
      if (lk_s2_r == lk_s3_r) begin
        lk_stable_r <= lk_s3_r;
      end
    end
  end

  // lock flag: cleared on enable, set after the lock has held for the settle time
  always_comb begin
    lock_flag_nxt = lock_flag_r;
    if (!pll_en_r || en_rise || !lk_stable_r) begin
      lock_flag_nxt = 1'b0;
    end else if (settle_cnt_r == 8'(SETTLE_CYC - 1)) begin
      lock_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_cnt_r <= 8'h00;
      lock_flag_r <= 1'b0;
    end else begin
      lock_flag_r <= lock_flag_nxt;
      if (lock_flag_nxt != 1'b0 || !pll_en_r || en_rise || !lk_stable_r) begin
        settle_cnt_r <= 8'h00;
      end else begin
        settle_cnt_r <= settle_cnt_r + 8'h01;
      end
    end
  end

  // wanted selection; the pll is only taken once locked, 111 falls back to the oscillator
  always_comb begin
    tgt = '0;
    tgt.fast_src = fhs_r;
    tgt.slow_src = fss_r;
    tgt.use_slow = (cks_r == 3'h0);
    tgt.div_log2 = tgt.use_slow ? 3'h0 : scps_div_of(cks_r);
    tgt.use_pll = pll_en_r & pll_os_r[2] & (pll_os_r[1:0] != PLL_CODE_RESERVED)
                  & lock_flag_r;
    tgt.pll_code = tgt.use_pll ? pll_os_r[1:0] : 2'h0;
  end

  // switch sequence: gate off, wait, change muxes, wait, gate on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_state_r <= SW_RUN;
      gap_cnt_r <= 3'h0;
      gate_r <= 1'b1;
      sw_done_r <= 1'b0;
      cur_r <= '0;
    end else begin
      sw_done_r <= 1'b0;
      unique case (sw_state_r)
        SW_RUN: begin
          if (tgt != cur_r) begin
            gate_r <= 1'b0;
            gap_cnt_r <= 3'h0;
            sw_state_r <= SW_GATE;
          end
        end
        SW_GATE: begin
          gap_cnt_r <= gap_cnt_r + 3'h1;
          if (gap_cnt_r == 3'(GAP_CYC - 1)) begin
            sw_state_r <= SW_LOAD;
          end
        end
        SW_LOAD: begin
          cur_r <= tgt;
          gap_cnt_r <= 3'h0;
          sw_state_r <= SW_UNGATE;
        end
        SW_UNGATE: begin
          gap_cnt_r <= gap_cnt_r + 3'h1;
          if (gap_cnt_r == 3'(GAP_CYC - 1)) begin
            gate_r <= 1'b1;
            sw_done_r <= 1'b1;
            sw_state_r <= SW_RUN;
          end
        end
      endcase
    end
  end

  // pll configuration; reference follows the selected fast oscillator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_cfg_r <= '0;
    end else begin
      pll_cfg_r.enable <= pll_en_r;
      pll_cfg_r.ref_ext <= fhs_r;
      pll_cfg_r.prediv2 <= ~pll_is_r;
      pll_cfg_r.mult <= PLL_MULT;
      pll_cfg_r.usb_en <= pll_en_r;
    end
  end

  // oscillator enables: old and new sources both run until the switch sequence loads the new selection into cur_r
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_run_r <= 4'h0;
      aux_r <= '0;
    end else begin
      osc_run_r[0] <= fhs_r | cur_r.fast_src;
      osc_run_r[1] <= ~fhs_r | ~cur_r.fast_src;
      osc_run_r[2] <= fss_r | cur_r.slow_src;
      osc_run_r[3] <= ~fss_r | ~cur_r.slow_src;
      aux_r.wdt_slow_src <= cur_r.slow_src;
      aux_r.tb_fast_src <= cur_r.fast_src;
      aux_r.tb_slow_src <= cur_r.slow_src;
    end
  end

  // sticky events; read clears only what was returned, a new event wins
  always_comb begin
    sts_nxt = sts_r;
    if (rd_go && scps_hit(avs_address, OFS_INT_STATUS)) begin
      sts_nxt = sts_r & ~rdata_r[2:0];
    end
    if (lock_flag_nxt && !lock_flag_r) begin
      sts_nxt[IRQ_LOCK_GAIN] = 1'b1;
    end
    if (!lock_flag_nxt && lock_flag_r && pll_en_r && !en_rise) begin
      sts_nxt[IRQ_LOCK_LOST] = 1'b1;
    end
    if (sw_done_r) begin
      sts_nxt[IRQ_SWITCH_DONE] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sts_r <= 3'h0;
      msk_r <= IRQ_MASK_RESET;
      irq_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      if (wr_go && scps_hit(avs_address, OFS_INT_MASK)) begin
        msk_r <= wbyte[2:0];
        irq_r <= |(sts_nxt & wbyte[2:0]);
      end else begin
        irq_r <= |(sts_nxt & msk_r);
      end
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign pll_cfg = pll_cfg_r;
  assign clk_sel = cur_r;
  assign sys_clk_gate = gate_r;
  assign osc_run = osc_run_r;
  assign aux_sel = aux_r;
  assign irq = irq_r;

  // helper: cycles the synchronised lock has held with the pll enabled
  logic [8:0] held_cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_cnt_r <= 9'h000;
    end else if (!pll_en_r || en_rise || !lk_stable_r) begin
      held_cnt_r <= 9'h000;
    end else if (held_cnt_r != 9'h1ff) begin
      held_cnt_r <= held_cnt_r + 9'h001;
    end
  end

  a_lock_clear_en: assert property (@(posedge clk) disable iff (rst)
    en_rise |=> !lock_flag_r ##1 !lock_flag_r)
    else $error("lock flag not cleared after enable");

  a_lock_settled: assert property (@(posedge clk) disable iff (rst)
    $rose(lock_flag_r) |-> $past(held_cnt_r) >= 9'(SETTLE_CYC - 1))
    else $error("lock flag set before settle time");

  a_rate_forced: assert property (@(posedge clk) disable iff (rst)
    !fhs_r |=> !pll_is_r)
    else $error("input rate not forced to 12 MHz with internal rc");

  a_pll_locked_use: assert property (@(posedge clk) disable iff (rst)
    (clk_sel.use_pll && sys_clk_gate) |-> $past(lock_flag_r))
    else $error("pll drives fast clock while unlocked");

  a_sel_gated: assert property (@(posedge clk) disable iff (rst)
    $changed(clk_sel) |-> !sys_clk_gate && !$past(sys_clk_gate) ##1 !sys_clk_gate)
    else $error("clock selection changed while gate open");

  a_gate_gap: assert property (@(posedge clk) disable iff (rst)
    $fell(sys_clk_gate) |-> !sys_clk_gate[*4])
    else $error("gate reopened too soon");

  a_switch_bound: assert property (@(posedge clk) disable iff (rst)
    $fell(sys_clk_gate) |-> ##[1:12] sys_clk_gate)
    else $error("clock switch did not finish");

  a_code_legal: assert property (@(posedge clk) disable iff (rst)
    clk_sel.use_pll |-> clk_sel.pll_code != PLL_CODE_RESERVED)
    else $error("reserved pll code in use");

  a_prediv_rate: assert property (@(posedge clk) disable iff (rst)
    pll_cfg.enable |-> pll_cfg.mult == PLL_MULT && pll_cfg.usb_en
      && pll_cfg.prediv2 == !$past(pll_is_r))
    else $error("pll divider or multiplier wrong");

  a_en_after_reset: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> pll_en_r)
    else $error("pll enable not set after reset");

  a_bus_answer: assert property (@(posedge clk) disable iff (rst)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("waitrequest held too long");

  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    sw_done_r && msk_r[IRQ_SWITCH_DONE] |=> irq)
    else $error("unmasked event did not raise irq");

  c_lock_gain: cover property (@(posedge clk) disable iff (rst) $rose(lock_flag_r));
  c_to_pll: cover property (@(posedge clk) disable iff (rst) $rose(clk_sel.use_pll));
  c_to_slow: cover property (@(posedge clk) disable iff (rst) $rose(clk_sel.use_slow));
  c_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));

endmodule

// file: src/scps_pkg.sv
// Purpose: shared constants and types of the system clock and pll select block
// Assumes: 20 MHz register clock, 8-bit registers on 32-bit avalon words
// Notes: oscillators and the pll itself are analog; this block only steers them
package scps_pkg;

  // register clock
  localparam int unsigned CLK_PERIOD_NS = 50;

  // register byte offsets
  localparam logic [4:0] OFS_SYS_CLOCK_CONTROL = 5'h00;
  localparam logic [4:0] OFS_PLL_CONTROL = 5'h04;
  localparam logic [4:0] OFS_INT_STATUS = 5'h08;
  localparam logic [4:0] OFS_INT_MASK = 5'h0c;
  localparam logic [4:0] OFS_CLK_STATUS = 5'h10;

  // sys_clock_control fields
  localparam int unsigned SCC_CKS_LSB = 5;
  localparam int unsigned SCC_FHS_BIT = 3;
  localparam int unsigned SCC_FSS_BIT = 2;
  localparam logic [7:0] SCC_RESET = 8'he0;

  // pll_control fields
  localparam int unsigned PLL_CONTROL_EN_BIT = 0;
  localparam int unsigned PLL_CONTROL_LOCK_BIT = 1;
  localparam int unsigned PLL_CONTROL_OS_LSB = 2;
  localparam int unsigned PLL_CONTROL_IS_BIT = 5;
  localparam int unsigned PLL_CONTROL_RSV_BIT = 7;
  localparam logic [7:0] PLL_CONTROL_RESET = 8'h01;

  // interrupt status bits
  localparam int unsigned IRQ_LOCK_GAIN = 0;
  localparam int unsigned IRQ_LOCK_LOST = 1;
  localparam int unsigned IRQ_SWITCH_DONE = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // pll output codes (low two bits of the output select field)
  localparam logic [1:0] PLL_CODE_RESERVED = 2'h3;
  localparam logic [3:0] PLL_MULT = 4'h8;

  // timing: pll settle after lock indication, gap around a clock switch
  localparam int unsigned PLL_SETTLE_NS = 10000;
  localparam int unsigned SWITCH_GAP_NS = 200;
  localparam int unsigned SETTLE_CYC = (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYC = (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // clock tree selection applied to the glitch-free muxes
  typedef struct packed {
    logic fast_src;      // 1 = ext_fast_crystal, 0 = int_fast_rc
    logic slow_src;      // 1 = ext_slow_crystal, 0 = int_slow_rc
    logic use_slow;      // system runs from the slow clock
    logic [2:0] div_log2; // fast_clock divide exponent
    logic use_pll;       // fast_clock taken from pll_sys_clock
    logic [1:0] pll_code; // 0 = 6 MHz, 1 = 12 MHz, 2 = 16 MHz
  } scps_clk_sel_t;

  // analog pll configuration
  typedef struct packed {
    logic enable;
    logic ref_ext;       // reference from ext_fast_crystal, else int_fast_rc
    logic prediv2;       // halve the reference before the multiplier
    logic [3:0] mult;
    logic usb_en;        // 48 MHz usb clock output enabled
  } scps_pll_cfg_t;

  // clock sources for watchdog and time base
  typedef struct packed {
    logic wdt_slow_src;
    logic tb_fast_src;
    logic tb_slow_src;
  } scps_aux_sel_t;

endpackage

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the clock select and pll control block
// Assumes: avalon-mm slave answers in its own time; lock pin driven by the bench
// Notes: switch timing is waited for with a fixed settle, long enough for a full switch
`timescale 1ns/100ps

module tb_top
  import scps_pkg::*;
;

  logic clk;
  logic rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pll_locked_pin;
  scps_pll_cfg_t pll_cfg;
  scps_clk_sel_t clk_sel;
  logic sys_clk_gate;
  logic [3:0] osc_run;
  scps_aux_sel_t aux_sel;
  logic irq;
  int err_total;
  int checks_done;
  logic [2:0] code;

  scps_ctrl DUT (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pll_locked_pin(pll_locked_pin), .pll_cfg(pll_cfg), .clk_sel(clk_sel),
    .sys_clk_gate(sys_clk_gate), .osc_run(osc_run), .aux_sel(aux_sel), .irq(irq)
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // compare one value and count it
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus transfer; the request holds until waitrequest is sampled low at a rising edge
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] wd, output logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_read <= ~wr;
    avs_write <= wr;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) chk(32'h1, 32'h0);
    // read data is taken at the accepting edge, then the request is released
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr(input logic [4:0] a, input logic [7:0] wd);
    logic [31:0] d;
    bus(1'b1, a, wd, d);
  endtask

  // read a register and compare its low byte
  task rdc(input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 8'h00, d);
    chk(d, {24'h0, exp});
  endtask

  // read until the masked bits match, bounded
  task poll(input logic [4:0] a, input logic [7:0] m, input logic [7:0] v);
    int n;
    logic [31:0] d;
    for (n = 0; n < 400; n++) begin
      bus(1'b0, a, 8'h00, d);
      if ((d[7:0] & m) === v) break;
    end
    chk(d & {24'h0, m}, {24'h0, v});
  endtask

  // a switch takes about ten cycles; thirty leaves margin
  task settle;
    repeat (30) @(posedge clk);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // hang guard, far beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end

  // main sequence
  initial begin
    err_total = 0;
    checks_done = 0;
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    pll_locked_pin = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // reset state of registers and outputs
    rdc(OFS_SYS_CLOCK_CONTROL, 8'he0);
    rdc(OFS_PLL_CONTROL, 8'h01);
    rdc(OFS_INT_MASK, 8'h00);
    rdc(5'h14, 8'h00);
    chk({31'h0, pll_cfg.enable}, 32'h1);
    chk({31'h0, pll_cfg.usb_en}, 32'h1);
    chk({28'h0, pll_cfg.mult}, 32'h8);
    chk({31'h0, pll_cfg.prediv2}, 32'h1);
    chk({28'h0, osc_run}, 32'ha);
    // input rate bit held low while the internal rc is the fast source
    wr(OFS_PLL_CONTROL, 8'h21);
    rdc(OFS_PLL_CONTROL, 8'h01);
    // both external sources, fast clock divided by four
    wr(OFS_SYS_CLOCK_CONTROL, 8'hac);
    settle();
    chk({31'h0, clk_sel.fast_src}, 32'h1);
    chk({31'h0, clk_sel.slow_src}, 32'h1);
    chk({29'h0, clk_sel.div_log2}, 32'h2);
    chk({31'h0, clk_sel.use_slow}, 32'h0);
    chk({29'h0, aux_sel}, 32'h7);
    chk({28'h0, osc_run}, 32'h5);
    chk({31'h0, sys_clk_gate}, 32'h1);
    rdc(OFS_CLK_STATUS, 8'h18);
    chk({31'h0, irq}, 32'h0);
    // switch-done event raises irq once unmasked, a status read clears it
    wr(OFS_INT_MASK, 8'h04);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    poll(OFS_INT_STATUS, 8'h04, 8'h04);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rdc(OFS_INT_STATUS, 8'h00);
    // a write without byte lane zero is dropped
    avs_byteenable <= 4'he;
    wr(OFS_SYS_CLOCK_CONTROL, 8'h00);
    avs_byteenable <= 4'h1;
    rdc(OFS_SYS_CLOCK_CONTROL, 8'hac);
    // external crystal at 6 MHz: no halving stage
    wr(OFS_PLL_CONTROL, 8'h21);
    rdc(OFS_PLL_CONTROL, 8'h21);
    repeat (2) @(posedge clk);
    chk({31'h0, pll_cfg.prediv2}, 32'h0);
    chk({31'h0, pll_cfg.ref_ext}, 32'h1);
    // run from the slow clock, then back to the fast one
    wr(OFS_SYS_CLOCK_CONTROL, 8'h0c);
    settle();
    chk({31'h0, clk_sel.use_slow}, 32'h1);
    wr(OFS_SYS_CLOCK_CONTROL, 8'he8);
    settle();
    chk({31'h0, clk_sel.use_slow}, 32'h0);
    chk({31'h0, clk_sel.slow_src}, 32'h0);
    chk({29'h0, aux_sel}, 32'h2);
    chk({29'h0, clk_sel.div_log2}, 32'h0);
    // disable then re-enable the pll with output code 100
    wr(OFS_PLL_CONTROL, 8'h20);
    repeat (2) @(posedge clk);
    chk({31'h0, pll_cfg.usb_en}, 32'h0);
    chk({31'h0, pll_cfg.enable}, 32'h0);
    wr(OFS_PLL_CONTROL, 8'h31);
    rdc(OFS_PLL_CONTROL, 8'h31);
    pll_locked_pin <= 1'b1;
    repeat (50) @(posedge clk);
    chk({31'h0, clk_sel.use_pll}, 32'h0);
    poll(OFS_PLL_CONTROL, 8'h02, 8'h02);
    settle();
    chk({31'h0, clk_sel.use_pll}, 32'h1);
    chk({30'h0, clk_sel.pll_code}, 32'h0);
    rdc(OFS_CLK_STATUS, 8'h0a);
    chk({31'h0, pll_cfg.usb_en}, 32'h1);
    // remaining pll codes keep the lock and move the system rate
    for (int i = 1; i < 3; i++) begin
      code = 3'h4 + i[2:0];
      wr(OFS_PLL_CONTROL, {3'h1, code, 2'h1});
      settle();
      chk({31'h0, clk_sel.use_pll}, 32'h1);
      chk({30'h0, clk_sel.pll_code}, i);
    end
    // code 0xx falls back to the oscillator, code 111 stays there
    wr(OFS_PLL_CONTROL, 8'h2d);
    settle();
    chk({31'h0, clk_sel.use_pll}, 32'h0);
    wr(OFS_PLL_CONTROL, 8'h3d);
    settle();
    chk({31'h0, clk_sel.use_pll}, 32'h0);
    wr(OFS_PLL_CONTROL, 8'h39);
    settle();
    chk({31'h0, clk_sel.use_pll}, 32'h1);
    // losing lock drops the flag and leaves the pll
    wr(OFS_INT_MASK, 8'h02);
    pll_locked_pin <= 1'b0;
    settle();
    chk({31'h0, clk_sel.use_pll}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rdc(OFS_PLL_CONTROL, 8'h39);
    poll(OFS_INT_STATUS, 8'h02, 8'h02);
    final_report();
  end

endmodule
